// ---- rtl/block_lock_cell.sv ----
`timescale 1ns/1ps
module block_lock_cell (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operation request
  input wire logic sel_i,
  input wire stacked_mem_pkg::lock_op_t op_i,
  input wire logic wp_n_i,
  // block state
  output logic locked_o,
  output logic locked_down_o
);
  import stacked_mem_pkg::*;

  // lock bit; blocks come out of reset locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_o <= 1'b1;
    end else if (sel_i) begin
      unique case (op_i)
        LOCK_SET, LOCK_DOWN: locked_o <= 1'b1;
        LOCK_CLEAR: begin
          if (!locked_down_o || wp_n_i) begin
            locked_o <= 1'b0;
          end
        end
        LOCK_NONE: locked_o <= locked_o;
      endcase
    end
  end

  // lock-down bit, cleared only by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_down_o <= 1'b0;
    end else if (sel_i && op_i == LOCK_DOWN) begin
      locked_down_o <= 1'b1;
    end
  end
endmodule

// ---- rtl/stacked_mem_ctrl_pins.sv ----
`timescale 1ns/1ps
`include "stacked_mem_params.svh"
module stacked_mem_ctrl_pins (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // shared address and data pins
  input wire logic [`ADDR_W-1:0] ADDR_I,
  input wire logic [`DATA_W-1:0] DQ_I,
  output logic [`DATA_W-1:0] DQ_O,
  output logic [1:0] DQ_OE_N_O,
  // flash control pins
  input wire logic FL_CE_N_I,
  input wire logic FL_OE_N_I,
  input wire logic FL_WE_N_I,
  input wire logic FL_RST_N_I,
  input wire logic FL_WP_N_I,
  input wire logic ADDRESS_VALID_N_I,
  output logic WAIT_O,
  output logic WAIT_OE_N_O,
  // ram control pins
  input wire logic RAM_CS_N_I,
  input wire logic RAM_OE_N_I,
  input wire logic RAM_WE_N_I,
  input wire logic RAM_UPPER_BYTE_EN_N_I,
  input wire logic RAM_LOWER_BYTE_EN_N_I,
  input wire logic PSRAM_MODE_N_I,
  input wire logic PSRAM_CFG_REG_ENABLE_I
);
  import stacked_mem_pkg::*;

  logic rst_flash;
  logic [15:0] read_cfg;
  logic [15:0] refresh_ctrl;
  logic [15:0] bus_ctrl;
  logic sync_mode;
  logic wait_pol;
  logic adv_low;
  logic fl_we_prev;
  logic ram_we_prev;
  logic fl_we_rise;
  logic ram_we_rise;
  logic [`ADDR_W-1:0] addr_latched;
  logic captured;
  logic [`ADDR_W-1:0] burst;
  logic [2:0] lat;
  logic [`ADDR_W-1:0] flash_addr;
  logic [`ADDR_W-1:0] wr_addr;
  logic [`DATA_W-1:0] wr_data;
  logic cmd_valid;
  cmd_state_t cmd_state;
  lock_op_t lock_op;
  logic [`NUM_BLOCKS-1:0] locked;
  logic [`NUM_BLOCKS-1:0] locked_down;
  logic [`BLK_SEL_W-1:0] op_blk;
  logic [`BLK_SEL_W-1:0] rd_blk;
  logic [`DATA_W-1:0] ram_mem [0:`RAM_DEPTH-1];
  logic [`RAM_ADDR_W-1:0] ram_addr;
  logic low_power;
  logic ram_active;
  logic flash_read;
  logic ram_read;
  logic sync_read;
  logic wait_asserted;
  logic bus_req;
  logic [31:0] next_rdata;

  assign rst_flash = SYS_RST_I || !FL_RST_N_I;
  assign sync_mode = read_cfg[`SYNC_MODE_BIT];
  assign wait_pol = read_cfg[`WAIT_POL_BIT];
  assign adv_low = !ADDRESS_VALID_N_I;
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // previous write-enable levels for rising-edge detection
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      fl_we_prev <= 1'b1;
      ram_we_prev <= 1'b1;
    end else begin
      fl_we_prev <= FL_WE_N_I;
      ram_we_prev <= RAM_WE_N_I;
    end
  end
  assign fl_we_rise = !fl_we_prev && FL_WE_N_I && !FL_CE_N_I && FL_RST_N_I;
  assign ram_we_rise = !ram_we_prev && RAM_WE_N_I && !RAM_CS_N_I;

  // wishbone ack, one cycle after the request, dropped the next cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // read configuration; flash reset returns it to asynchronous mode
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_flash) begin
      read_cfg <= `READ_CFG_RESET;
    end else if (bus_req && WB_WE_I && WB_ADR_I == `REG_READ_CFG) begin
      if (WB_SEL_I[0]) begin
        read_cfg[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        read_cfg[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // bus read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (WB_ADR_I)
      `REG_READ_CFG: next_rdata = {16'h0000, read_cfg};
      `REG_STATUS: next_rdata = {28'h000_0000, low_power, captured, sync_mode, !FL_RST_N_I};
      `REG_LOCK_MAP: next_rdata = {16'h0000, locked_down, locked};
      `REG_PSRAM_CFG: next_rdata = {bus_ctrl, refresh_ctrl};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end

  // address capture and burst advance
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_flash) begin
      addr_latched <= '0;
      captured <= 1'b0;
      burst <= '0;
      lat <= 3'h0;
    end else if (sync_mode) begin
      if (adv_low && !captured) begin
        addr_latched <= ADDR_I;
        captured <= 1'b1;
        burst <= '0;
        lat <= `SYNC_LATENCY;
      end else begin
        if (!adv_low) begin
          captured <= 1'b0;
        end
        if (!FL_CE_N_I && lat != 3'h0) begin
          lat <= lat - 3'h1;
        end else if (!FL_CE_N_I) begin
          burst <= burst + `ADDR_W'(1);
        end
      end
    end else begin
      captured <= 1'b0;
      burst <= '0;
      lat <= 3'h0;
      if (adv_low) begin
        addr_latched <= ADDR_I;
      end
    end
  end
  // flow-through while address valid is held low in asynchronous mode
  assign flash_addr = (!sync_mode && adv_low) ? ADDR_I : addr_latched + burst;

  // address and data latched on the write-enable rising edge
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_flash) begin
      wr_addr <= '0;
      wr_data <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= fl_we_rise;
      if (fl_we_rise) begin
        wr_addr <= flash_addr;
        wr_data <= DQ_I;
      end
    end
  end

  // two-step lock command sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_flash) begin
      cmd_state <= CMD_IDLE;
    end else if (cmd_valid) begin
      unique case (cmd_state)
        CMD_IDLE: cmd_state <= (wr_data == `CMD_LOCK_SETUP) ? CMD_SETUP : CMD_IDLE;
        CMD_SETUP: cmd_state <= CMD_IDLE;
      endcase
    end
  end

  // decode the second command cycle into a block operation
  always_comb begin
    lock_op = LOCK_NONE;
    if (cmd_valid && cmd_state == CMD_SETUP) begin
      unique case (wr_data)
        `CMD_LOCK: lock_op = LOCK_SET;
        `CMD_UNLOCK: lock_op = LOCK_CLEAR;
        `CMD_LOCKDOWN: lock_op = LOCK_DOWN;
        default: lock_op = LOCK_NONE;
      endcase
    end
  end
  assign op_blk = wr_addr[`ADDR_W-1 -: `BLK_SEL_W];
  assign rd_blk = flash_addr[`ADDR_W-1 -: `BLK_SEL_W];

  // one protection cell per block
  genvar b;
  generate
    for (b = 0; b < `NUM_BLOCKS; b++) begin : g_blk
      block_lock_cell u_cell (
        .clk_i(CLK_SYS_I),
        .rst_i(rst_flash),
        .sel_i(op_blk == `BLK_SEL_W'(b)),
        .op_i(lock_op),
        .wp_n_i(FL_WP_N_I),
        .locked_o(locked[b]),
        .locked_down_o(locked_down[b])
      );
    end
  endgenerate

  // psram low-power entry and exit
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      low_power <= 1'b0;
    end else if (!PSRAM_MODE_N_I && RAM_CS_N_I) begin
      low_power <= 1'b1;
    end else if (!RAM_CS_N_I && PSRAM_MODE_N_I) begin
      low_power <= 1'b0;
    end
  end
  assign ram_active = !RAM_CS_N_I && !low_power;
  assign ram_addr = ADDR_I[`RAM_ADDR_W-1:0];

  // psram configuration writes
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      refresh_ctrl <= `REFRESH_CTRL_RESET;
      bus_ctrl <= `BUS_CTRL_RESET;
    end else if (ram_we_rise && !low_power && (PSRAM_CFG_REG_ENABLE_I || !PSRAM_MODE_N_I)) begin
      if (ADDR_I[0]) begin
        bus_ctrl <= DQ_I;
      end else begin
        refresh_ctrl <= DQ_I;
      end
    end
  end

  // ram array writes, byte lane by byte lane
  always_ff @(posedge CLK_SYS_I) begin
    if (ram_we_rise && !low_power && !PSRAM_CFG_REG_ENABLE_I && PSRAM_MODE_N_I) begin
      if (!RAM_UPPER_BYTE_EN_N_I) begin
        ram_mem[ram_addr][15:8] <= DQ_I[15:8];
      end
      if (!RAM_LOWER_BYTE_EN_N_I) begin
        ram_mem[ram_addr][7:0] <= DQ_I[7:0];
      end
    end
  end

  // read selection; a flash in reset drives nothing
  assign flash_read = !FL_CE_N_I && !FL_OE_N_I && FL_WE_N_I && FL_RST_N_I;
  assign ram_read = ram_active && !RAM_OE_N_I && RAM_WE_N_I;
  assign sync_read = sync_mode && flash_read;

  // data pins register; flash returns block protection state
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      DQ_O <= '0;
    end else if (flash_read) begin
      DQ_O <= {14'h0000, locked_down[rd_blk], locked[rd_blk]};
    end else if (ram_read) begin
      DQ_O <= ram_mem[ram_addr];
    end
  end

  // data pin enables, low while driving
  always_comb begin
    DQ_OE_N_O = 2'b11;
    if (flash_read) begin
      DQ_OE_N_O = 2'b00;
    end else if (ram_read) begin
      DQ_OE_N_O[1] = RAM_UPPER_BYTE_EN_N_I;
      DQ_OE_N_O[0] = RAM_LOWER_BYTE_EN_N_I;
    end
  end

  // wait: invalid data during sync latency, also asserted outside sync reads, deasserted once burst data is valid
  assign wait_asserted = sync_read ? (lat != 3'h0 || adv_low) : 1'b1;
  assign WAIT_O = wait_pol ? wait_asserted : !wait_asserted;
  assign WAIT_OE_N_O = FL_CE_N_I;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  // checks next to the logic above
  lockdown_holds_a: assert property (
    (cmd_valid && lock_op == LOCK_CLEAR && locked_down[op_blk] && locked[op_blk] && !FL_WP_N_I
      && FL_RST_N_I) |=> locked[$past(op_blk)])
    else $error("locked-down block unlocked while write protect low");
  unlock_allowed_a: assert property (
    (lock_op == LOCK_CLEAR && FL_WP_N_I && FL_RST_N_I) |=> !locked[$past(op_blk)])
    else $error("unlock refused while write protect high");
  sync_capture_a: assert property (
    (sync_mode && adv_low && !captured && FL_RST_N_I && $stable(read_cfg))
      |=> (addr_latched == $past(ADDR_I)) && captured)
    else $error("sync address not captured at first valid clock");
  async_flow_a: assert property (
    (!sync_mode && adv_low) |-> flash_addr == ADDR_I)
    else $error("async address not flowing through");
  async_hold_a: assert property (
    (!sync_mode && adv_low ##1 !adv_low && !sync_mode && FL_RST_N_I) |-> flash_addr == $past(ADDR_I))
    else $error("async address not held after valid rise");
  byte_lanes_a: assert property (
    (ram_read && !flash_read) |-> DQ_OE_N_O == {RAM_UPPER_BYTE_EN_N_I, RAM_LOWER_BYTE_EN_N_I})
    else $error("ram byte lanes do not follow byte enables");
  reset_async_a: assert property (
    !FL_RST_N_I |=> !sync_mode && cmd_state == CMD_IDLE && !cmd_valid)
    else $error("flash reset did not return to async read array");
  reset_quiet_a: assert property (
    !FL_RST_N_I |-> DQ_OE_N_O == 2'b11 || ram_read)
    else $error("flash drives data while in reset");
  wait_float_a: assert property (
    FL_CE_N_I |-> WAIT_OE_N_O)
    else $error("wait driven while flash deselected");
  wait_write_a: assert property (
    (!FL_CE_N_I && !FL_WE_N_I) |-> WAIT_O == wait_pol)
    else $error("wait not asserted during flash write");
  burst_step_a: assert property (
    (sync_mode && !FL_CE_N_I && !adv_low && lat == 3'h0 && FL_RST_N_I ##1 sync_mode && FL_RST_N_I && !adv_low)
      |-> burst == $past(burst) + `ADDR_W'(1))
    else $error("burst address did not advance");
  cfg_load_a: assert property (
    (ram_we_rise && !low_power && PSRAM_CFG_REG_ENABLE_I && !ADDR_I[0]) |=> refresh_ctrl == $past(DQ_I))
    else $error("refresh control not loaded by config write");
  low_power_a: assert property (
    (!PSRAM_MODE_N_I && RAM_CS_N_I) |=> low_power)
    else $error("psram did not enter low power");

  // main scenarios
  lockdown_cover_c: cover property (lock_op == LOCK_DOWN ##[1:50] lock_op == LOCK_CLEAR);
  sync_burst_cover_c: cover property ((sync_read && lat == 3'h0) [*4]);
  ram_write_cover_c: cover property (ram_we_rise && !RAM_UPPER_BYTE_EN_N_I && RAM_LOWER_BYTE_EN_N_I);
  psram_cfg_cover_c: cover property (ram_we_rise && PSRAM_CFG_REG_ENABLE_I);
endmodule

// ---- rtl/stacked_mem_params.svh ----
`ifndef STACKED_MEM_PARAMS_SVH
`define STACKED_MEM_PARAMS_SVH

// pin and array widths
`define ADDR_W 16
`define DATA_W 16
`define NUM_BLOCKS 8
`define BLK_SEL_W 3
`define RAM_DEPTH 16
`define RAM_ADDR_W 4

// register byte offsets on the bus
`define REG_READ_CFG 8'h00
`define REG_STATUS 8'h04
`define REG_LOCK_MAP 8'h08
`define REG_PSRAM_CFG 8'h0C

// read configuration fields and reset value
`define READ_CFG_RESET 16'h0000
`define WAIT_POL_BIT 10
`define SYNC_MODE_BIT 15

// psram configuration reset values
`define REFRESH_CTRL_RESET 16'h0000
`define BUS_CTRL_RESET 16'h0000

// flash command codes seen on the data pins
`define CMD_LOCK_SETUP 16'h0060
`define CMD_LOCK 16'h0001
`define CMD_UNLOCK 16'h00D0
`define CMD_LOCKDOWN 16'h002F

// first-access latency of a synchronous read, in clocks
`define SYNC_LATENCY 3'h2

`endif

// ---- rtl/stacked_mem_pkg.sv ----
package stacked_mem_pkg;

  // flash command sequencer states
  typedef enum logic [0:0] {
    CMD_IDLE,
    CMD_SETUP
  } cmd_state_t;

  // operations on one block's protection state
  typedef enum logic [1:0] {
    LOCK_NONE,
    LOCK_SET,
    LOCK_CLEAR,
    LOCK_DOWN
  } lock_op_t;

endpackage

// ---- verif/host_bus_model.sv ----
`timescale 1ns/1ps
`include "stacked_mem_params.svh"
module host_bus_model (
  // clock and returned pins
  input wire logic clk_i,
  input wire logic [`DATA_W-1:0] dq_i,
  input wire logic [1:0] dq_oe_n_i,
  input wire logic wait_i,
  // shared pins
  output logic [`ADDR_W-1:0] addr_o,
  output logic [`DATA_W-1:0] dq_o,
  output logic adv_n_o,
  // flash strobes
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  // ram strobes
  output logic ram_cs_n_o,
  output logic ram_oe_n_o,
  output logic ram_we_n_o,
  output logic [1:0] ram_be_n_o
);
  // idle bus at time zero
  initial begin
    addr_o = 16'h0000;
    dq_o = 16'h0000;
    adv_n_o = 1'b1;
    fl_ce_n_o = 1'b1;
    fl_oe_n_o = 1'b1;
    fl_we_n_o = 1'b1;
    ram_cs_n_o = 1'b1;
    ram_oe_n_o = 1'b1;
    ram_we_n_o = 1'b1;
    ram_be_n_o = 2'b11;
  end

  // release strobes; released data lines flip so stale data never matches
  task automatic idle();
    @(posedge clk_i);
    adv_n_o <= 1'b1;
    fl_ce_n_o <= 1'b1;
    fl_oe_n_o <= 1'b1;
    ram_cs_n_o <= 1'b1;
    ram_oe_n_o <= 1'b1;
    ram_be_n_o <= 2'b11;
    dq_o <= ~dq_o;
  endtask

  // flash write, address and data held across the write-enable rise
  task automatic flash_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    dq_o <= d;
    adv_n_o <= 1'b0;
    fl_ce_n_o <= 1'b0;
    fl_we_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    fl_we_n_o <= 1'b1;
    idle();
    repeat (3) @(posedge clk_i);
  endtask

  // flash read: address a while valid is low, then b once valid is high
  task automatic flash_rd(input logic [15:0] a, input logic [15:0] b, output logic [15:0] d, output logic w);
    @(posedge clk_i);
    addr_o <= a;
    adv_n_o <= 1'b0;
    fl_ce_n_o <= 1'b0;
    fl_oe_n_o <= 1'b0;
    @(posedge clk_i);
    addr_o <= b;
    adv_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    d = dq_i;
    w = wait_i;
    idle();
  endtask

  // ram write with byte enables
  task automatic ram_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_i);
    addr_o <= a;
    dq_o <= d;
    ram_cs_n_o <= 1'b0;
    ram_we_n_o <= 1'b0;
    ram_be_n_o <= be;
    @(posedge clk_i);
    ram_we_n_o <= 1'b1;
    idle();
    @(posedge clk_i);
  endtask

  // ram read, returns data and lane drive enables
  task automatic ram_rd(input logic [15:0] a, input logic [1:0] be, output logic [15:0] d, output logic [1:0] oe);
    @(posedge clk_i);
    addr_o <= a;
    ram_cs_n_o <= 1'b0;
    ram_oe_n_o <= 1'b0;
    ram_be_n_o <= be;
    repeat (2) @(posedge clk_i);
    d = dq_i;
    oe = dq_oe_n_i;
    idle();
  endtask
endmodule

// ---- verif/stacked_mem_ctrl_pins_tb.sv ----
`timescale 1ns/1ps
`include "stacked_mem_params.svh"
module stacked_mem_ctrl_pins_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [1:0] dq_oe_n;
  logic [1:0] be_n;
  logic adv_n, fce_n, foe_n, fwe_n, rcs_n, roe_n, rwe_n, wait_s, wait_oe_n;
  logic frst_n = 1'b1;
  logic wp_n = 1'b1;
  logic mode_n = 1'b1;
  logic cre = 1'b0;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] r;
  logic [15:0] d;
  logic [1:0] oe;
  logic w;

  // 100 MHz clock
  always #5 clk = ~clk;

  stacked_mem_ctrl_pins i_dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .ADDR_I(addr), .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_N_O(dq_oe_n),
    .FL_CE_N_I(fce_n), .FL_OE_N_I(foe_n), .FL_WE_N_I(fwe_n), .FL_RST_N_I(frst_n),
    .FL_WP_N_I(wp_n), .ADDRESS_VALID_N_I(adv_n), .WAIT_O(wait_s), .WAIT_OE_N_O(wait_oe_n),
    .RAM_CS_N_I(rcs_n), .RAM_OE_N_I(roe_n), .RAM_WE_N_I(rwe_n),
    .RAM_UPPER_BYTE_EN_N_I(be_n[1]), .RAM_LOWER_BYTE_EN_N_I(be_n[0]),
    .PSRAM_MODE_N_I(mode_n), .PSRAM_CFG_REG_ENABLE_I(cre));

  host_bus_model host (
    .clk_i(clk), .dq_i(dq_out), .dq_oe_n_i(dq_oe_n), .wait_i(wait_s), .addr_o(addr), .dq_o(dq_in),
    .adv_n_o(adv_n), .fl_ce_n_o(fce_n), .fl_oe_n_o(foe_n), .fl_we_n_o(fwe_n),
    .ram_cs_n_o(rcs_n), .ram_oe_n_o(roe_n), .ram_we_n_o(rwe_n), .ram_be_n_o(be_n));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hF;
    wdat <= wd;
    // no timeout here; only the hang guard ends a wait for an ack that never comes
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // two-write lock command sequence
  task automatic lock_cmd(input logic [15:0] a, input logic [15:0] c);
    host.flash_wr(a, `CMD_LOCK_SETUP);
    host.flash_wr(a, c);
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("lock map", r, 32'h0000_00FF);
    wb(1'b0, 8'h00, 32'h0000_0000, r);
    chk("read cfg", r, 32'h0000_0000);
    wb(1'b0, 8'h40, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
    chk("wait float", {31'h0, wait_oe_n}, 32'h0000_0001);
    $display("test reset done");
    lock_cmd(16'h2000, `CMD_UNLOCK);
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("unlock", r, 32'h0000_00FD);
    lock_cmd(16'h4000, `CMD_LOCKDOWN);
    wp_n <= 1'b0;
    lock_cmd(16'h4000, `CMD_UNLOCK);
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("lockdown held", {30'h0, r[10], r[2]}, 32'h0000_0003);
    wp_n <= 1'b1;
    lock_cmd(16'h4000, `CMD_UNLOCK);
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("lockdown lifted", {31'h0, r[2]}, 32'h0000_0000);
    $display("test locks done");
    host.flash_rd(16'h2100, 16'h2100, d, w);
    chk("async data", {16'h0000, d}, 32'h0000_0000);
    chk("async wait", {31'h0, w}, 32'h0000_0000);
    host.flash_rd(16'h2100, 16'hE000, d, w);
    chk("adv latch", {16'h0000, d}, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0400, r);
    host.flash_rd(16'h0100, 16'h0100, d, w);
    chk("async blk0", {16'h0000, d}, 32'h0000_0001);
    chk("wait polarity", {31'h0, w}, 32'h0000_0001);
    wb(1'b1, 8'h00, 32'h0000_8400, r);
    host.flash_rd(16'h2100, 16'hE000, d, w);
    chk("sync capture", {16'h0000, d}, 32'h0000_0000);
    chk("sync wait", {31'h0, w}, 32'h0000_0000);
    $display("test reads done");
    frst_n <= 1'b0;
    repeat (2) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk("flash in reset", {31'h0, r[0]}, 32'h0000_0001);
    frst_n <= 1'b1;
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("relocked", r, 32'h0000_00FF);
    wb(1'b0, 8'h00, 32'h0000_0000, r);
    chk("cfg cleared", r, 32'h0000_0000);
    host.flash_rd(16'h2100, 16'h2100, d, w);
    chk("array after reset", {15'h0, d, w}, 32'h0000_0002);
    $display("test flash reset done");
    host.ram_wr(16'h0003, 16'hA5C3, 2'b00);
    host.ram_wr(16'h0003, 16'h7711, 2'b01);
    host.ram_wr(16'h0003, 16'h2266, 2'b10);
    host.ram_rd(16'h0003, 2'b00, d, oe);
    chk("ram lanes", {16'h0000, d}, 32'h0000_7766);
    host.ram_rd(16'h0003, 2'b01, d, oe);
    chk("upper lane", {22'h0, oe, d[15:8]}, 32'h0000_0177);
    host.ram_rd(16'h0003, 2'b10, d, oe);
    chk("lower lane", {22'h0, oe, d[7:0]}, 32'h0000_0266);
    $display("test ram lanes done");
    host.ram_wr(16'h0000, 16'hBEEF, 2'b00);
    cre <= 1'b1;
    host.ram_wr(16'h0000, 16'h1234, 2'b00);
    host.ram_wr(16'h0001, 16'h5678, 2'b00);
    cre <= 1'b0;
    wb(1'b0, 8'h0C, 32'h0000_0000, r);
    chk("psram cfg", r, 32'h5678_1234);
    host.ram_rd(16'h0000, 2'b00, d, oe);
    chk("array kept", {16'h0000, d}, 32'h0000_BEEF);
    // mode pin dropped while selected: the write goes to bus control
    fork
      host.ram_wr(16'h0001, 16'h4321, 2'b00);
      begin
        @(posedge clk);
        mode_n <= 1'b0;
      end
    join
    wb(1'b0, 8'h0C, 32'h0000_0000, r);
    chk("mode cfg", r, 32'h4321_1234);
    mode_n <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk("low power", {31'h0, r[3]}, 32'h0000_0001);
    mode_n <= 1'b1;
    host.ram_rd(16'h0000, 2'b00, d, oe);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk("awake", {31'h0, r[3]}, 32'h0000_0000);
    host.ram_rd(16'h0000, 2'b00, d, oe);
    chk("ram after wake", {16'h0000, d}, 32'h0000_BEEF);
    $display("test psram done");
    wrap_up();
  end
endmodule
